// *** hw/serial_ctl_pkg.sv ***
// package: offsets, field positions and reset values of the serial port control block
`default_nettype none
package serial_ctl_pkg;
	localparam logic [11:0] CTRL_STATUS_OFFSET = 12'h004;
	localparam logic [11:0] CAPACITY_OFFSET = 12'h000;
	localparam int RX_ON_BIT = 0;
	localparam int TX_ON_BIT = 1;
	localparam int TX_READY_BIT = 8;
	localparam int RX_READY_BIT = 10;
	localparam int CAPACITY_LSB = 24;
	localparam logic RX_ON_RESET = 1'b0;
	localparam logic TX_ON_RESET = 1'b0;
	localparam logic [31:0] RDATA_RESET = 32'h00000000;
endpackage
`default_nettype wire

// *** hw/serial_port_control_status.sv ***
// serial port control and status registers with ready flag logic
// Functional notes
// - capacity is a read-only byte at bits 24 to 31.
// - writing rx_on one starts reception at once; read returns the state.
// - clearing rx_on stops reception and flushes the receive buffer.
// - writing tx_on one starts transmission at once; read returns the state.
// - written 0 disables, written 1 enables, for both bits.
// - tx_ready_flag set exactly while tx_on set and tx_room_count was nonzero one cycle earlier.
// - rx_ready_flag set exactly while rx_on set and rx_fill_count was nonzero one cycle earlier.
// - ready flags read 1 ready, 0 not ready; writes to them ignored.
// - clearing tx_on stops transmission at once, pending characters dropped.
`default_nettype none
module serial_port_control_status #(
	parameter int CNT_W = 8,
	parameter logic [7:0] BUF_CAPACITY = 8'h04
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_sys_rst,
	// register access
	input wire logic [11:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] i_wdata,
	output logic [31:0] o_rdata,
	// buffer occupancy from the data path
	input wire logic [CNT_W-1:0] i_tx_room_count,
	input wire logic [CNT_W-1:0] i_rx_fill_count,
	// controls to the data path
	output logic o_rx_on,
	output logic o_tx_on,
	output logic o_rx_flush,
	output logic o_tx_abort,
	output logic o_tx_ready_flag,
	output logic o_rx_ready_flag
);
	logic rx_on_q;
	logic tx_on_q;
	logic rx_flush_q;
	logic tx_abort_q;
	logic tx_ready_q;
	logic rx_ready_q;
	logic [31:0] rdata_q;

	wire logic sel_ctrl = i_addr == serial_ctl_pkg::CTRL_STATUS_OFFSET;
	wire logic sel_cap = i_addr == serial_ctl_pkg::CAPACITY_OFFSET;
	wire logic ctrl_wr = i_wr && sel_ctrl;
	// only bits 0 and 1 are writable; flags and reserved bits drop writes
	wire logic rx_on_d = ctrl_wr ? i_wdata[serial_ctl_pkg::RX_ON_BIT]
		: rx_on_q;
	wire logic tx_on_d = ctrl_wr ? i_wdata[serial_ctl_pkg::TX_ON_BIT]
		: tx_on_q;
	// flags follow the next enable so they never lag a disable write
	wire logic tx_ready_d = (i_tx_room_count != '0) && tx_on_d;
	wire logic rx_ready_d = (i_rx_fill_count != '0) && rx_on_d;
	// words built from package positions so the map lives in one place
	logic [31:0] ctrl_word;
	logic [31:0] cap_word;
	always_comb begin
		ctrl_word = 32'h00000000;
		ctrl_word[serial_ctl_pkg::RX_ON_BIT] = rx_on_q;
		ctrl_word[serial_ctl_pkg::TX_ON_BIT] = tx_on_q;
		ctrl_word[serial_ctl_pkg::TX_READY_BIT] = tx_ready_q;
		ctrl_word[serial_ctl_pkg::RX_READY_BIT] = rx_ready_q;
	end
	always_comb begin
		cap_word = 32'h00000000;
		cap_word[serial_ctl_pkg::CAPACITY_LSB +: 8] = BUF_CAPACITY;
	end
	wire logic [31:0] rdata_d = !i_rd ? rdata_q
		: sel_ctrl ? ctrl_word : sel_cap ? cap_word : 32'h00000000;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rx_on_q <= serial_ctl_pkg::RX_ON_RESET;
		end else begin
			rx_on_q <= rx_on_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			tx_on_q <= serial_ctl_pkg::TX_ON_RESET;
		end else begin
			tx_on_q <= tx_on_d;
		end
	end

	// one-cycle strobe so the data path empties the buffer only once
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rx_flush_q <= 1'b0;
		end else begin
			rx_flush_q <= rx_on_q && !rx_on_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			tx_abort_q <= 1'b0;
		end else begin
			tx_abort_q <= tx_on_q && !tx_on_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			tx_ready_q <= 1'b0;
		end else begin
			tx_ready_q <= tx_ready_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rx_ready_q <= 1'b0;
		end else begin
			rx_ready_q <= rx_ready_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rdata_q <= serial_ctl_pkg::RDATA_RESET;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rx_on = rx_on_q;
	assign o_tx_on = tx_on_q;
	assign o_rx_flush = rx_flush_q;
	assign o_tx_abort = tx_abort_q;
	assign o_tx_ready_flag = tx_ready_q;
	assign o_rx_ready_flag = rx_ready_q;
	assign o_rdata = rdata_q;

	a_rx_on_write: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		ctrl_wr |=>
		o_rx_on == $past(i_wdata[serial_ctl_pkg::RX_ON_BIT]))
		else $error("rx_on did not follow write");
	a_tx_on_write: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		ctrl_wr |=>
		o_tx_on == $past(i_wdata[serial_ctl_pkg::TX_ON_BIT]))
		else $error("tx_on did not follow write");
	a_rx_flush_pulse: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		$fell(o_rx_on) && !$past(i_sys_rst) |-> o_rx_flush)
		else $error("no flush on rx disable");
	a_tx_abort_pulse: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		$fell(o_tx_on) && !$past(i_sys_rst) |-> o_tx_abort)
		else $error("no abort on tx disable");
	a_rx_flush_only: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		o_rx_flush |-> $past(o_rx_on) && !o_rx_on)
		else $error("flush without rx disable");
	a_tx_abort_only: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		o_tx_abort |-> $past(o_tx_on) && !o_tx_on)
		else $error("abort without tx disable");
	a_rx_on_hold: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		!ctrl_wr |=> $stable(o_rx_on))
		else $error("rx_on changed without write");
	a_tx_on_hold: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		!ctrl_wr |=> $stable(o_tx_on))
		else $error("tx_on changed without write");
	a_tx_ready_rel: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		o_tx_ready_flag ==
		($past(i_tx_room_count) != '0 && o_tx_on))
		else $error("tx ready flag wrong");
	a_rx_ready_rel: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		o_rx_ready_flag ==
		($past(i_rx_fill_count) != '0 && o_rx_on))
		else $error("rx ready flag wrong");
	a_tx_flag_gate: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		!o_tx_on |-> !o_tx_ready_flag)
		else $error("tx ready while tx off");
	a_rx_flag_gate: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		!o_rx_on |-> !o_rx_ready_flag)
		else $error("rx ready while rx off");
	a_cap_read: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		i_rd && sel_cap |=>
		o_rdata[serial_ctl_pkg::CAPACITY_LSB +: 8] == BUF_CAPACITY
		&& o_rdata[23:0] == 24'h000000)
		else $error("capacity read wrong");
	a_ctrl_reserved: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		i_rd && sel_ctrl |=> o_rdata[31:11] == 21'h00000
		&& o_rdata[9] == 1'b0 && o_rdata[7:2] == 6'h00)
		else $error("reserved bits not zero");
	a_flag_read: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		i_rd && sel_ctrl |=>
		o_rdata[serial_ctl_pkg::TX_READY_BIT] == $past(o_tx_ready_flag)
		&& o_rdata[serial_ctl_pkg::RX_READY_BIT] == $past(o_rx_ready_flag))
		else $error("flag read wrong");
	a_rdata_hold: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		!i_rd |=> $stable(o_rdata))
		else $error("read data moved without read");
	a_unmapped_read: assert property (
		@(posedge i_clock) disable iff (i_sys_rst)
		i_rd && !sel_ctrl && !sel_cap |=> o_rdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_reset_state: assert property (
		@(posedge i_clock)
		i_sys_rst |=> !o_rx_on && !o_tx_on && !o_rx_flush
		&& !o_tx_abort && !o_tx_ready_flag && !o_rx_ready_flag
		&& o_rdata == 32'h00000000)
		else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// *** verification/buf_count_model.sv ***
// receive buffer count stand-in for the serial port data path
`default_nettype none
module buf_count_model (
	input wire logic i_clock,
	input wire logic i_sys_rst,
	input wire logic i_rx_flush,
	input wire logic [7:0] i_rx_set,
	output logic [7:0] o_rx_fill_count
);
	timeunit 1ns;
	timeprecision 100ps;
	// a zero load keeps the count, so only a flush or reset can empty it
	always_ff @(posedge i_clock) o_rx_fill_count <= (i_sys_rst || i_rx_flush)
		? 8'h00 : (i_rx_set != 8'h00 ? i_rx_set : o_rx_fill_count);
endmodule
`default_nettype wire

// *** verification/serial_port_control_status_tb.sv ***
// bench for the serial port control and status block
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
	bad_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module serial_port_control_status_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic rx_on, tx_on, flush, abort, txr, rxr;
	logic [11:0] addr = 12'h000;
	logic [31:0] wd = 32'h00000000, rdata;
	logic [7:0] room = 8'h00, rx_set = 8'h00, fill;
	int bad_count = 0, comparisons = 0;
	always #12.5 clk = ~clk;
	buf_count_model i_model (.i_clock(clk), .i_sys_rst(rst),
		.i_rx_flush(flush), .i_rx_set(rx_set), .o_rx_fill_count(fill));
	serial_port_control_status i_dut (.i_clock(clk), .i_sys_rst(rst),
		.i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wd), .o_rdata(rdata),
		.i_tx_room_count(room), .i_rx_fill_count(fill), .o_rx_on(rx_on),
		.o_tx_on(tx_on), .o_rx_flush(flush), .o_tx_abort(abort),
		.o_tx_ready_flag(txr), .o_rx_ready_flag(rxr));
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		addr <= a; wr <= w; rd <= !w; wd <= d;
		@(posedge clk);
		wr <= 1'b0; rd <= 1'b0;
		#1;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h00000000);
		`CHK("rdata", e, rdata)
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// far longer than the short access sequence below
	initial begin #50us; bad_count++; report_and_stop(); end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rchk(12'h004, 32'h00000000);
		acc(1'b1, 12'h000, 32'h00000000);
		rchk(12'h000, 32'h04000000);
		acc(1'b1, 12'h004, 32'hFFFFFFFC);
		rchk(12'h004, 32'h00000000);
		@(posedge clk);
		room <= 8'h02;
		rx_set <= 8'h03;
		acc(1'b1, 12'h004, 32'hFFFFFFFF);
		`CHK("rx_on", 1'b1, rx_on)
		`CHK("tx_on", 1'b1, tx_on)
		`CHK("tx_ready", 1'b1, txr)
		`CHK("rx_ready", 1'b1, rxr)
		rchk(12'h004, 32'h00000503);
		@(posedge clk);
		room <= 8'h00;
		rx_set <= 8'h00;
		rchk(12'h004, 32'h00000403);
		rchk(12'h008, 32'h00000000);
		acc(1'b1, 12'h004, 32'h00000000);
		`CHK("flush", 1'b1, flush)
		`CHK("abort", 1'b1, abort)
		`CHK("rx_on", 1'b0, rx_on)
		`CHK("rx_ready", 1'b0, rxr)
		acc(1'b1, 12'h004, 32'h00000001);
		`CHK("flush", 1'b0, flush)
		rchk(12'h004, 32'h00000001);
		$display("test registers done");
		report_and_stop();
	end
endmodule
`default_nettype wire
